// >>> lin_host_model.sv
// host side model: periodic watchdog kicks
`timescale 1ns/1ns
module lin_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic kick_en,
  output logic      wd_kick_n
);
  logic [9:0] phase;
  // 600 cycle period stays well inside the shortened watchdog timeout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase     <= 10'h000;
      wd_kick_n <= 1'b1;
    end else begin
      phase     <= (phase == 10'h257) ? 10'h000 : phase + 10'h001;
      wd_kick_n <= !(kick_en && phase < 10'h12C);
    end
  end
endmodule

// >>> lin_mode_defs.svh
// constants for the lin transceiver mode controller
`ifndef LIN_MODE_DEFS_SVH
`define LIN_MODE_DEFS_SVH
`define CLK_MHZ            250
`define DEBOUNCE_US        160
`define DEBOUNCE_CYC       (`DEBOUNCE_US * `CLK_MHZ)
`define RESET_HOLD_MS      4
`define RESET_HOLD_CYC     (`RESET_HOLD_MS * 1000 * `CLK_MHZ)
`define SLEEP_SKEW_NS      3200
`define SLEEP_SKEW_CYC     ((`SLEEP_SKEW_NS * `CLK_MHZ + 999) / 1000)
`define BUS_WAKE_CYC       2500
`define KICK_MIN_CYC       250
`define WD_TIMEOUT_CYC     100000
`define RAMP_CYC           1000
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_WAKE           8'h08
`define STAT_MODE_LSB      0
`define STAT_RESET_BIT     5
`define STAT_FAST_BIT      6
`define STAT_WD_BIT        7
`endif

// >>> lin_mode_pkg.sv
// types for the lin transceiver mode controller
package lin_mode_pkg;
  typedef enum logic [4:0] {
    ST_FAILSAFE = 5'h01,
    ST_NORMAL   = 5'h02,
    ST_SILENT   = 5'h04,
    ST_SLEEP    = 5'h08,
    ST_PENDING  = 5'h10
  } mode_t;
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_BUS   = 2'h1,
    SRC_LOCAL = 2'h2,
    SRC_BATT  = 2'h3
  } wake_src_t;
  typedef enum logic [1:0] {
    RST_NONE = 2'h0,
    RST_UV   = 2'h1,
    RST_WD   = 2'h2
  } rst_src_t;
endpackage

// >>> lin_mode_sva.sv
// concurrent checks on the mode controller ports
`timescale 1ns/1ns
module lin_mode_sva #(
  parameter int RESET_HOLD_CYC = 50
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        divider_en,
  input wire logic        fast_slew_sel,
  input wire logic        undervoltage,
  input wire logic        rxd_out,
  input wire logic        reset_out_n,
  input wire logic        ext_supply_switch,
  input wire logic        divider_out,
  input wire logic        regulator_on,
  input wire logic        slope_ctrl_off,
  input wire logic        bus_drive_dominant,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since reset release, saturating
  logic [31:0] held;
  always_ff @(posedge aclk) begin
    if (!aresetn) held <= '0;
    else if (held < RESET_HOLD_CYC) held <= held + 32'h1;
  end
  AST_POWERUP_HOLD: assert property (held < RESET_HOLD_CYC - 1 |-> !reset_out_n)
    else $error("reset released before hold time");
  AST_SLEEP_OUTPUTS: assert property (!regulator_on |->
    !reset_out_n && !rxd_out && !ext_supply_switch && !divider_out)
    else $error("sleep outputs not all low");
  // four cycles leave room for the registered divider output
  AST_DIVIDER_OFF: assert property ((!divider_en)[*4] |-> !divider_out)
    else $error("divider on while its input is low");
  AST_SLOPE_SEL: assert property ((!fast_slew_sel)[*4] |-> !slope_ctrl_off)
    else $error("slope control off without speed select");
  AST_SLOPE_SUPPLY: assert property (slope_ctrl_off |-> ext_supply_switch && regulator_on)
    else $error("normal mode without supply switch");
  AST_UV_RESET: assert property (undervoltage[*4] |-> !reset_out_n)
    else $error("undervoltage without reset");
  // mode follows the pin one cycle later, the output one more
  AST_RESET_FAILSAFE: assert property ((!reset_out_n)[*3] |-> !slope_ctrl_off)
    else $error("normal mode kept under reset");
  AST_TX_GATED: assert property (bus_drive_dominant |-> ext_supply_switch && reset_out_n)
    else $error("bus driven outside normal mode");
  AST_AXI_WRITE_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AXI_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_AXI_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind lin_transceiver_mode_control lin_mode_sva #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .divider_en(divider_en), .fast_slew_sel(fast_slew_sel),
  .undervoltage(undervoltage), .rxd_out(rxd_out), .reset_out_n(reset_out_n),
  .ext_supply_switch(ext_supply_switch), .divider_out(divider_out), .regulator_on(regulator_on),
  .slope_ctrl_off(slope_ctrl_off), .bus_drive_dominant(bus_drive_dominant),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));

// >>> lin_transceiver_mode_control.sv
// operating-mode controller of a lin transceiver with regulator and watchdog
// Functional notes
// - normal mode: receive data follows bus level
// - enable high selects normal mode
// - enable falls, txd high: silent mode
// - enable falls, txd low: sleep mode
// - txd may lag enable by 3.2us
// - strap high disables the watchdog
// - ignition rising edge, debounced, wakes device
// - sleep allowed while ignition is high
// - supply switch on in normal, fail-safe
// - reset low on undervoltage or watchdog failure
// - kick counts: falling edge, long low
// - divider follows input, off in sleep
// - speed select disables slope control in normal
// - normal mode watchdog active, needs kicks
// - reset low in normal: go fail-safe
// - silent undervoltage: reset low, fail-safe
// - low power entry ignores wake pin levels
// - low bus level enables receiver, timer
// - bus wake: fall, long dominant, rise
// - silent bus wake: fail-safe, rxd low
// - sleep bus wake: fail-safe, regulator on
// - sleep: reset, rxd low, outputs off
// - after ramp, enable high gives normal
// - fail-safe until enable high
// - power-up reset held low 4 ms
// - fail-safe pins encode wake source
// - after reset pins encode reset source
`timescale 1ns/1ns
`include "lin_mode_defs.svh"
module lin_transceiver_mode_control
  import lin_mode_pkg::*;
#(
  parameter int RESET_HOLD_CYC = `RESET_HOLD_CYC,
  parameter int WD_TIMEOUT_CYC = `WD_TIMEOUT_CYC,
  parameter int DEBOUNCE_CYC   = `DEBOUNCE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable_in,
  input  wire logic        txd_in,
  input  wire logic        bus_in,
  input  wire logic        bus_prewake,
  input  wire logic        local_wake_n,
  input  wire logic        ignition_in,
  input  wire logic        wd_kick_n,
  input  wire logic        wd_disable,
  input  wire logic        divider_en,
  input  wire logic        fast_slew_sel,
  input  wire logic        undervoltage,
  input  wire logic        batt_undervoltage,
  output logic             rxd_out,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             reset_out_n,
  output logic             ext_supply_switch,
  output logic             divider_out,
  output logic             regulator_on,
  output logic             slope_ctrl_off,
  output logic             bus_drive_dominant,
  output logic             bus_rx_enable,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  mode_t      mode;
  wake_src_t  wake_src;
  rst_src_t   rst_src;
  logic       en_q;
  logic       kick_q;
  logic       ign_q;
  logic       bus_q;
  logic       ign_armed;
  logic [31:0] rst_cnt;
  logic [31:0] wd_cnt;
  logic [31:0] kick_cnt;
  logic [31:0] ign_cnt;
  logic [31:0] bus_cnt;
  logic [31:0] skew_cnt;
  logic [31:0] ramp_cnt;
  logic       kick_low;
  logic       wd_fail;
  logic       bus_fell;
  logic       bus_long;
  logic       bus_wake;
  logic       ign_wake;
  logic       loc_wake;
  logic       wd_run;
  logic       sw_wd_off;
  logic       sw_force_fs;
  logic       en_fall;
  logic [31:0] next_rdata;
  logic       aw_done;
  logic       w_done;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // pins already synchronous to aclk; one stage used only for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q   <= 1'b0;
      kick_q <= 1'b1;
      ign_q  <= 1'b0;
      bus_q  <= 1'b1;
    end else begin
      en_q   <= enable_in;
      kick_q <= wd_kick_n;
      ign_q  <= ignition_in;
      bus_q  <= bus_in;
    end
  end

  assign en_fall = en_q && !enable_in;
  wire low_power = (mode == ST_SILENT) || (mode == ST_SLEEP);
  assign wd_run = !wd_disable && !sw_wd_off && !low_power && (mode != ST_PENDING);

  // kick: falling edge then low longer than the minimum
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_cnt <= 32'h0;
      kick_low <= 1'b0;
    end else if (wd_kick_n) begin
      kick_cnt <= 32'h0;
      kick_low <= 1'b0;
    end else if (kick_q || kick_cnt != 32'h0) begin
      kick_cnt <= kick_cnt + 32'h1;
      kick_low <= (kick_cnt == 32'(`KICK_MIN_CYC));
    end else begin
      kick_low <= 1'b0;
    end
  end

  // window timing not modelled; a plain timeout stands for it
  always_ff @(posedge aclk) begin
    if (!aresetn || !wd_run || !reset_out_n || kick_low) begin
      wd_cnt  <= 32'h0;
      wd_fail <= 1'b0;
    end else begin
      wd_cnt  <= wd_cnt + 32'h1;
      wd_fail <= (wd_cnt == 32'(WD_TIMEOUT_CYC - 1));
    end
  end

  // ignition: only a rising edge arms, debounce while high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ign_cnt   <= 32'h0;
      ign_armed <= 1'b0;
    end else if (!ignition_in || !low_power) begin
      ign_cnt   <= 32'h0;
      ign_armed <= 1'b0;
    end else if (!ign_q) begin
      ign_armed <= 1'b1;
      ign_cnt   <= 32'h0;
    end else if (ign_armed) begin
      ign_cnt <= ign_cnt + 32'h1;
    end
  end
  assign ign_wake = ign_armed && (ign_cnt == 32'(DEBOUNCE_CYC - 1));
  assign loc_wake = ign_wake;

  // bus wake: falling edge, long dominant, rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn || !low_power) begin
      bus_cnt  <= 32'h0;
      bus_fell <= 1'b0;
      bus_long <= 1'b0;
    end else if (bus_q && !bus_in && bus_prewake) begin
      bus_fell <= 1'b1;
      bus_cnt  <= 32'h0;
      bus_long <= 1'b0;
    end else if (bus_fell && !bus_in) begin
      bus_cnt <= bus_cnt + 32'h1;
      if (bus_cnt == 32'(`BUS_WAKE_CYC))
        bus_long <= 1'b1;
    end else if (bus_in) begin
      bus_fell <= 1'b0;
      bus_long <= 1'b0;
      bus_cnt  <= 32'h0;
    end
  end
  assign bus_wake = bus_fell && bus_long && bus_in &&
                    ((mode == ST_SLEEP) || txd_in);

  // enable may fall up to the skew before txd on the way to sleep
  always_ff @(posedge aclk) begin
    if (!aresetn || mode != ST_NORMAL || enable_in) begin
      skew_cnt <= 32'h0;
    end else if (skew_cnt != 32'h0 || en_fall) begin
      skew_cnt <= skew_cnt + 32'h1;
    end
  end

  // mode sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode     <= ST_FAILSAFE;
      wake_src <= SRC_NONE;
    end else begin
      unique case (mode)
        ST_FAILSAFE: begin
          if (enable_in && rst_cnt == 32'h0 && reset_out_n && !sw_force_fs) begin
            mode     <= ST_NORMAL;
            wake_src <= SRC_NONE;
          end
        end
        ST_NORMAL: begin
          if (!reset_out_n || sw_force_fs) begin
            mode <= ST_FAILSAFE;
          end else if (!enable_in && !txd_in) begin
            mode <= ST_SLEEP;
          end else if (!enable_in && skew_cnt == 32'(`SLEEP_SKEW_CYC)) begin
            mode <= ST_SILENT;
          end
        end
        ST_SILENT: begin
          if (undervoltage || batt_undervoltage) begin
            mode     <= ST_FAILSAFE;
            wake_src <= batt_undervoltage ? SRC_BATT : SRC_NONE;
          end else if (bus_wake) begin
            mode     <= ST_FAILSAFE;
            wake_src <= SRC_BUS;
          end else if (loc_wake) begin
            mode     <= ST_FAILSAFE;
            wake_src <= SRC_LOCAL;
          end else if (enable_in) begin
            mode <= ST_NORMAL;
          end
        end
        ST_SLEEP: begin
          if (batt_undervoltage) begin
            mode     <= ST_PENDING;
            wake_src <= SRC_BATT;
          end else if (bus_wake) begin
            mode     <= ST_PENDING;
            wake_src <= SRC_BUS;
          end else if (loc_wake) begin
            mode     <= ST_PENDING;
            wake_src <= SRC_LOCAL;
          end else if (enable_in) begin
            mode <= ST_PENDING;
          end
        end
        ST_PENDING: begin
          if (ramp_cnt == 32'(`RAMP_CYC)) begin
            mode <= ST_FAILSAFE;
          end
        end
      endcase
    end
  end

  // regulator ramp after sleep; the reset hold, loaded in sleep, counts down in fail-safe
  always_ff @(posedge aclk) begin
    if (!aresetn || mode != ST_PENDING) begin
      ramp_cnt <= 32'h0;
    end else begin
      ramp_cnt <= ramp_cnt + 32'h1;
    end
  end

  // reset output hold and source capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt <= 32'(RESET_HOLD_CYC);
      rst_src <= RST_NONE;
    end else if (mode == ST_SLEEP || mode == ST_PENDING) begin
      rst_cnt <= 32'(RESET_HOLD_CYC);
    end else if (undervoltage) begin
      rst_cnt <= 32'(RESET_HOLD_CYC);
      rst_src <= RST_UV;
    end else if (wd_fail) begin
      rst_cnt <= 32'(RESET_HOLD_CYC);
      rst_src <= RST_WD;
    end else if (rst_cnt != 32'h0) begin
      rst_cnt <= rst_cnt - 32'h1;
    end else if (mode == ST_NORMAL) begin
      rst_src <= RST_NONE;
    end
  end

  // pin and driver gate share one cycle, so no dominant bit leaks past a reset
  wire next_reset_n = (rst_cnt == 32'h0) && !undervoltage && !wd_fail &&
                      (mode != ST_SLEEP) && (mode != ST_PENDING);

  // outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_out_n        <= 1'b0;
      rxd_out            <= 1'b1;
      txd_out            <= 1'b1;
      txd_oe             <= 1'b0;
      ext_supply_switch  <= 1'b1;
      divider_out        <= 1'b0;
      regulator_on       <= 1'b1;
      slope_ctrl_off     <= 1'b0;
      bus_drive_dominant <= 1'b0;
      bus_rx_enable      <= 1'b0;
    end else begin
      reset_out_n       <= next_reset_n;
      ext_supply_switch <= (mode == ST_NORMAL) || (mode == ST_FAILSAFE);
      divider_out       <= divider_en && (mode != ST_SLEEP) && (mode != ST_PENDING);
      regulator_on      <= (mode != ST_SLEEP);
      slope_ctrl_off    <= (mode == ST_NORMAL) && fast_slew_sel;
      bus_drive_dominant <= (mode == ST_NORMAL) && enable_in && !txd_in && next_reset_n;
      bus_rx_enable     <= (mode == ST_NORMAL) || (low_power && bus_prewake);
      txd_oe            <= 1'b0;
      txd_out           <= 1'b1;
      unique case (mode)
        ST_NORMAL: rxd_out <= bus_in;
        ST_SILENT: rxd_out <= 1'b1;
        ST_SLEEP, ST_PENDING: rxd_out <= 1'b0;
        ST_FAILSAFE: begin
          txd_oe <= 1'b1;
          if (rst_src != RST_NONE) begin
            txd_out <= 1'b1;
            rxd_out <= (rst_src == RST_WD);
          end else begin
            unique case (wake_src)
              SRC_BUS:   begin txd_out <= 1'b0; rxd_out <= 1'b0; end
              SRC_LOCAL: begin txd_out <= 1'b0; rxd_out <= 1'b1; end
              SRC_BATT:  begin txd_out <= 1'b1; rxd_out <= 1'b0; end
              SRC_NONE:  begin txd_out <= 1'b1; rxd_out <= 1'b1; txd_oe <= 1'b0; end
            endcase
          end
        end
      endcase
    end
  end

  // axi4-lite slave, one write and one read at a time
  assign s_axi_awready = !aw_done && !s_axi_bvalid;
  assign s_axi_wready  = !w_done && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done      <= 1'b0;
      w_done       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      sw_wd_off    <= 1'b0;
      sw_force_fs  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_done && w_done) begin
        aw_done      <= 1'b0;
        w_done       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `REG_CTRL) begin
          s_axi_bresp <= 2'h0;
          if (w_strb[0]) begin
            sw_wd_off   <= w_data[0];
            sw_force_fs <= w_data[1];
          end
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    unique case (s_axi_araddr)
      `REG_CTRL:   next_rdata = {30'h0, sw_force_fs, sw_wd_off};
      `REG_STATUS: next_rdata = {24'h0, wd_run, slope_ctrl_off, reset_out_n, mode};
      `REG_WAKE:   next_rdata = {28'h0, rst_src, wake_src};
      default:     next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= (s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_STATUS ||
                       s_axi_araddr == `REG_WAKE) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> tb_lin_transceiver_mode_control.sv
// self-checking bench for the mode controller
`timescale 1ns/1ns
module tb_lin_transceiver_mode_control;
  logic aclk = 0, aresetn = 0, enable_in = 0, txd_in = 1, bus_in = 1, bus_prewake = 0;
  logic ignition_in = 0, wd_disable = 1, divider_en = 0, fast_slew_sel = 0;
  logic undervoltage = 0, kick_en = 0, wd_kick_n;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [1:0] rr;
  logic rxd_out, reset_out_n, ext_supply_switch, divider_out, regulator_on, slope_ctrl_off;
  logic awready, wready, bvalid, arready, rvalid;
  logic txd_out, txd_oe, bus_drive_dominant, bus_rx_enable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0, comparisons = 0;
  initial forever #2 aclk = ~aclk;
  lin_host_model host_u (.aclk(aclk), .aresetn(aresetn), .kick_en(kick_en),
    .wd_kick_n(wd_kick_n));
  lin_transceiver_mode_control #(.RESET_HOLD_CYC(50), .WD_TIMEOUT_CYC(2000),
    .DEBOUNCE_CYC(20)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .enable_in(enable_in), .txd_in(txd_in), .bus_in(bus_in),
    .bus_prewake(bus_prewake), .local_wake_n(1'b1), .ignition_in(ignition_in),
    .wd_kick_n(wd_kick_n), .wd_disable(wd_disable), .divider_en(divider_en),
    .fast_slew_sel(fast_slew_sel), .undervoltage(undervoltage), .batt_undervoltage(1'b0),
    .rxd_out(rxd_out), .txd_out(txd_out), .txd_oe(txd_oe), .reset_out_n(reset_out_n),
    .ext_supply_switch(ext_supply_switch), .divider_out(divider_out),
    .regulator_on(regulator_on), .slope_ctrl_off(slope_ctrl_off),
    .bus_drive_dominant(bus_drive_dominant), .bus_rx_enable(bus_rx_enable),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic fail(input string msg);
    failures++;
    $display("FAIL %0t %s", $time, msg);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) fail(msg);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 200; i++) begin
      // handshakes read while settled, acted on after the edge that takes them
      @(negedge aclk);
      aw_ok = awvalid && (awready === 1'b1);
      w_ok = wvalid && (wready === 1'b1);
      b_ok = (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
      if (b_ok) break;
    end
    if (i == 200) begin
      fail("write timeout");
      results();
    end
    bready <= 0;
    chk(resp, 2'h0, "write response");
  endtask
  task automatic rdreg(input logic [7:0] a);
    int i;
    logic ar_ok, r_ok;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 200; i++) begin
      @(negedge aclk);
      ar_ok = arvalid && (arready === 1'b1);
      r_ok = (rvalid === 1'b1);
      rd = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 0;
      if (r_ok) break;
    end
    if (i == 200) begin
      fail("read timeout");
      results();
    end
    rready <= 0;
    @(posedge aclk);
  endtask
  // polls the one-hot mode field, bounded
  task automatic wait_mode(input logic [4:0] m);
    int i;
    for (i = 0; i < 1000; i++) begin
      rdreg(8'h04);
      if (rd[4:0] === m) break;
    end
    chk(rd[4:0], m, "mode");
    if (rd[4:0] !== m) results();
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    int i;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk(reset_out_n, 1'b0, "power-up reset");
    chk(ext_supply_switch, 1'b1, "supply switch");
    wait_mode(5'h01);
    rdreg(8'hFC);
    chk(rr, 2'h2, "unmapped response");
    repeat (3000) @(posedge aclk);
    chk(reset_out_n, 1'b1, "watchdog strap");
    kick_en <= 1; wd_disable <= 0;
    $display("test failsafe done");
    enable_in <= 1;
    wait_mode(5'h02);
    bus_in <= 0;
    txd_in <= 0;
    repeat (5) @(posedge aclk);
    chk(rxd_out, 1'b0, "rxd dominant");
    chk(bus_drive_dominant, 1'b1, "transmit path");
    bus_in <= 1;
    txd_in <= 1;
    fast_slew_sel <= 1;
    divider_en <= 1;
    repeat (5) @(posedge aclk);
    chk(rxd_out, 1'b1, "rxd recessive");
    chk(slope_ctrl_off, 1'b1, "speed select");
    chk(divider_out, 1'b1, "divider");
    fast_slew_sel <= 0;
    wr(8'h00, 32'h2);
    wait_mode(5'h01);
    wr(8'h00, 32'h0);
    wait_mode(5'h02);
    $display("test normal done");
    enable_in <= 0;
    wait_mode(5'h04);
    chk(ext_supply_switch, 1'b0, "silent supply");
    chk(regulator_on, 1'b1, "silent regulator");
    bus_prewake <= 1;
    bus_in <= 0;
    repeat (2600) @(posedge aclk);
    chk(bus_rx_enable, 1'b1, "prewake receiver");
    chk(bus_drive_dominant, 1'b0, "silent transmit off");
    bus_in <= 1;
    bus_prewake <= 0;
    wait_mode(5'h01);
    chk({txd_oe, txd_out, rxd_out}, 3'h4, "wake rxd");
    rdreg(8'h08);
    chk(rd[1:0], 2'h1, "bus wake source");
    enable_in <= 1;
    wait_mode(5'h02);
    $display("test silent done");
    ignition_in <= 1;
    enable_in <= 0;
    repeat (600) @(posedge aclk);
    txd_in <= 0;
    wait_mode(5'h08);
    chk({reset_out_n, rxd_out, regulator_on, divider_out}, 4'h0, "sleep outputs");
    ignition_in <= 0;
    repeat (5) @(posedge aclk);
    // enable stays low so only the ignition edge can wake
    ignition_in <= 1;
    wait_mode(5'h10);
    chk(regulator_on, 1'b1, "ramp regulator");
    wait_mode(5'h01);
    chk({txd_oe, txd_out, rxd_out}, 3'h5, "local wake pins");
    rdreg(8'h08);
    chk(rd[1:0], 2'h2, "local wake source");
    txd_in <= 1;
    enable_in <= 1;
    wait_mode(5'h02);
    $display("test sleep done");
    kick_en <= 0;
    for (i = 0; i < 3000 && reset_out_n !== 1'b0; i++) @(negedge aclk);
    chk(reset_out_n, 1'b0, "watchdog reset");
    if (reset_out_n !== 1'b0) results();
    // mode follows the pin one edge later
    @(posedge aclk);
    rdreg(8'h04);
    chk(rd[4:0], 5'h01, "reset to failsafe");
    rdreg(8'h08);
    chk(rd[3:2], 2'h2, "watchdog source");
    chk({txd_oe, txd_out, rxd_out}, 3'h7, "watchdog pins");
    kick_en <= 1;
    wait_mode(5'h02);
    undervoltage <= 1; repeat (10) @(posedge aclk);
    chk(reset_out_n, 1'b0, "undervoltage reset");
    rdreg(8'h08);
    chk(rd[3:2], 2'h1, "undervoltage source");
    undervoltage <= 0;
    wait_mode(5'h02);
    $display("test reset done");
    results();
  end
endmodule
